// ### hdl/rol_pkg.sv
// constants shared by the reset option loader and its flash fetch engine
`default_nettype none
package rol_pkg;
  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int FADDR_W = 23;
  localparam int BYTE_W = 8;
  localparam int RADDR_W = 8;
  // --------------------------------------------------------------------------
  // flash global addresses of the option sources
  // --------------------------------------------------------------------------
  localparam logic [22:0] OPT_BYTE_ADDR = 23'h7f_ff0e;
  localparam logic [22:0] WAKE_TRIM_ADDR = 23'h40_00f0;
  localparam logic [22:0] HT_TRIM_ADDR = 23'h40_00f1;
  // --------------------------------------------------------------------------
  // option byte fields, trim and channel decode values
  // --------------------------------------------------------------------------
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_WIN_BIT = 3;
  localparam logic [2:0] RATE_LONGEST = 3'h7;
  localparam logic [3:0] HT_TRIM_GOOD = 4'h8;
  localparam logic [4:0] CH17_CODE = 5'h11;
  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WDOG = 8'h01;
  localparam logic [7:0] REG_WAKE = 8'h02;
  localparam logic [7:0] REG_HTTRIM = 8'h03;
  localparam logic [7:0] REG_VCTRL = 8'h04;
  localparam logic [7:0] REG_OPTION = 8'h05;
  localparam logic [7:0] RSVD_LO = 8'h10;
  localparam logic [7:0] RSVD_HI = 8'h1f;
  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'h00;
  localparam logic [2:0] RATE_RST = 3'h7;
  localparam logic [5:0] WAKE_RST = 6'h00;
  localparam logic [3:0] HT_RST = 4'h0;
endpackage
`default_nettype wire

// ### hdl/rol_fetch_if.sv
// handshake between the load sequencer and the flash fetch engine
`default_nettype none
interface rol_fetch_if;
  logic start;
  logic [22:0] addr;
  logic done;
  logic [7:0] data;
  logic fault;
  modport ctrl (output start, output addr, input done, input data, input fault);
  modport eng (input start, input addr, output done, output data, output fault);
endinterface
`default_nettype wire

// ### hdl/rol_fetch.sv
// single-byte flash read engine used during the reset load sequence
`default_nettype none
module rol_fetch (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // sequencer side
  rol_fetch_if.eng fif,
  // flash array read port
  output logic flash_rd_req,
  output logic [rol_pkg::FADDR_W-1:0] flash_addr,
  input wire logic [rol_pkg::BYTE_W-1:0] flash_rd_data,
  input wire logic flash_rd_valid,
  input wire logic flash_dbl_fault
);
  logic req_ff;
  logic [rol_pkg::FADDR_W-1:0] addr_ff;
  logic done_ff;
  logic [rol_pkg::BYTE_W-1:0] data_ff;
  logic fault_ff;

  // a reset drops a pending read at once; the array ignores the lost answer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      req_ff <= 1'b0;
      addr_ff <= '0;
      done_ff <= 1'b0;
      data_ff <= '0;
      fault_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (fif.start)
      begin
        req_ff <= 1'b1;
        addr_ff <= fif.addr;
      end
      else if (req_ff && flash_rd_valid)
      begin
        req_ff <= 1'b0;
        done_ff <= 1'b1;
        data_ff <= flash_rd_data;
        fault_ff <= flash_dbl_fault;
      end
    end
  end

  assign flash_rd_req = req_ff;
  assign flash_addr = addr_ff;
  assign fif.done = done_ff;
  assign fif.data = data_ff;
  assign fif.fault = fault_ff;
endmodule // rol_fetch
`default_nettype wire

// ### hdl/rol_loader.sv
// reset option loader: flash option copy, cpu stall and device-level wiring
`default_nettype none
module rol_loader (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // reset cause and oscillator strap
  input wire logic RST_POR_LVR,
  input wire logic RST_CLK_MON,
  input wire logic RST_SCM_STOP,
  input wire logic OSC_SELECT_INPUT,
  output logic OSC_LOOP_CTRL,
  // security and mode
  input wire logic SECURED,
  input wire logic SPECIAL_SC,
  output logic FORCE_SECURE,
  // flash controller
  input wire logic FLASH_CMD_ACTIVE,
  output logic FLASH_CMD_ABORT,
  output logic FLASH_RD_REQ,
  output logic [rol_pkg::FADDR_W-1:0] FLASH_ADDR,
  input wire logic [rol_pkg::BYTE_W-1:0] FLASH_RD_DATA,
  input wire logic FLASH_RD_VALID,
  input wire logic FLASH_DBL_FAULT,
  // cpu
  output logic CPU_HOLD,
  // loaded controls
  output logic [2:0] WATCHDOG_RATE,
  output logic WATCHDOG_WINDOW_EN,
  output logic [5:0] WAKEUP_TRIM,
  output logic [3:0] HIGH_TEMP_TRIM,
  // converter trigger sources and controls
  input wire logic PWM_CH1,
  input wire logic PWM_CH3,
  input wire logic PIT_TRIG0,
  input wire logic PIT_TRIG1,
  output logic [3:0] ADC_EXT_TRIG,
  input wire logic BDM_ACTIVE,
  output logic ADC_FREEZE,
  output logic BDM_ALT_CLK_OSC,
  input wire logic [4:0] ADC_CHAN_CODE,
  output logic CH17_ACTIVE,
  output logic CH17_BANDGAP,
  // register port
  input wire logic [rol_pkg::RADDR_W-1:0] REG_ADDR,
  input wire logic [rol_pkg::BYTE_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [rol_pkg::BYTE_W-1:0] REG_RDATA
);
  // --------------------------------------------------------------------------
  // types and state
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_OPT = 5'b00010,
    ST_WAKE = 5'b00100,
    ST_HT = 5'b01000,
    ST_RUN = 5'b10000
  } rol_state_e;

  rol_state_e state_ff;
  rol_state_e nxt_state;
  logic busy_ff;
  logic start_ff;
  logic [22:0] faddr_ff;
  logic hold_ff;
  logic abort_ff;
  logic fsec_ff;
  logic [7:0] option_ff;
  logic [2:0] rate_ff;
  logic win_ff;
  logic [5:0] wake_ff;
  logic [3:0] ht_ff;
  logic osc_ff;
  logic sens_sel_ff;
  logic [3:0] trig_ff;
  logic frz_ff;
  logic bdmclk_ff;
  logic ch17_ff;
  logic bg_ff;
  logic [7:0] rdata_ff;
  logic load_step;
  logic clk_check;

  rol_fetch_if fif ();

  function automatic logic in_rsvd(input logic [7:0] a);
    in_rsvd = (a >= rol_pkg::RSVD_LO) && (a <= rol_pkg::RSVD_HI);
  endfunction

  // --------------------------------------------------------------------------
  // flash fetch engine
  // --------------------------------------------------------------------------
  assign fif.start = start_ff;
  assign fif.addr = faddr_ff;

  rol_fetch u_fetch (
    .CLK(CLK),
    .RST(RST),
    .fif(fif),
    .flash_rd_req(FLASH_RD_REQ),
    .flash_addr(FLASH_ADDR),
    .flash_rd_data(FLASH_RD_DATA),
    .flash_rd_valid(FLASH_RD_VALID),
    .flash_dbl_fault(FLASH_DBL_FAULT)
  );

  // --------------------------------------------------------------------------
  // load sequencer
  // --------------------------------------------------------------------------
  assign load_step = busy_ff && fif.done;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: nxt_state = ST_OPT;
      ST_OPT: if (load_step) nxt_state = ST_WAKE;
      ST_WAKE: if (load_step) nxt_state = ST_HT;
      ST_HT: if (load_step) nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_RESET;
    endcase
  end

  // only control state resets here; no ram array is cleared or written
  always_ff @(posedge CLK)
  begin
    if (RST)
      state_ff <= ST_RESET;
    else
      state_ff <= nxt_state;
  end

  // one fetch per load state, started on entry
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      busy_ff <= 1'b0;
      start_ff <= 1'b0;
      faddr_ff <= '0;
    end
    else
    begin
      start_ff <= 1'b0;
      if (load_step)
        busy_ff <= 1'b0;
      else if (!busy_ff && (state_ff != ST_RESET) && (state_ff != ST_RUN))
      begin
        busy_ff <= 1'b1;
        start_ff <= 1'b1;
        unique case (state_ff)
          ST_OPT: faddr_ff <= rol_pkg::OPT_BYTE_ADDR;
          ST_WAKE: faddr_ff <= rol_pkg::WAKE_TRIM_ADDR;
          default: faddr_ff <= rol_pkg::HT_TRIM_ADDR;
        endcase
      end
    end
  end

  // stall held through reset and every load step
  always_ff @(posedge CLK)
  begin
    if (RST)
      hold_ff <= 1'b1;
    else
      hold_ff <= (nxt_state != ST_RUN);
  end

  // abort is asserted in the cycle after each reset cycle that sees a command running
  always_ff @(posedge CLK)
  begin
    abort_ff <= RST && FLASH_CMD_ACTIVE;
  end

  // protection starts clear each reset and is forced by any double fault
  always_ff @(posedge CLK)
  begin
    if (RST)
      fsec_ff <= 1'b0;
    else if (load_step && fif.fault)
      fsec_ff <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // loaded option registers, software may rewrite all but the option copy after load
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      option_ff <= rol_pkg::OPTION_RST;
      rate_ff <= rol_pkg::RATE_RST;
      win_ff <= 1'b0;
    end
    else if (load_step && (state_ff == ST_OPT))
    begin
      option_ff <= fif.data;
      win_ff <= ~fif.data[rol_pkg::OPT_WIN_BIT];
      if (SECURED && SPECIAL_SC)
        rate_ff <= rol_pkg::RATE_LONGEST;
      else
        rate_ff <= ~fif.data[rol_pkg::OPT_RATE_LSB +: 3];
    end
    else if (REG_WR && (REG_ADDR == rol_pkg::REG_WDOG) && (state_ff == ST_RUN))
    begin
      rate_ff <= REG_WDATA[2:0];
      win_ff <= REG_WDATA[3];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      wake_ff <= rol_pkg::WAKE_RST;
    else if (load_step && (state_ff == ST_WAKE))
      wake_ff <= fif.data[5:0];
    else if (REG_WR && (REG_ADDR == rol_pkg::REG_WAKE) && (state_ff == ST_RUN))
      wake_ff <= REG_WDATA[5:0];
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      ht_ff <= rol_pkg::HT_RST;
    else if (load_step && (state_ff == ST_HT))
      ht_ff <= fif.data[3:0];
    else if (REG_WR && (REG_ADDR == rol_pkg::REG_HTTRIM) && (state_ff == ST_RUN))
      ht_ff <= REG_WDATA[3:0];
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      sens_sel_ff <= 1'b0;
    else if (REG_WR && (REG_ADDR == rol_pkg::REG_VCTRL))
      sens_sel_ff <= REG_WDATA[0];
  end

  // --------------------------------------------------------------------------
  // oscillator strap: tracked while reset checks the clock, frozen after
  // --------------------------------------------------------------------------
  assign clk_check = RST_POR_LVR || RST_CLK_MON || RST_SCM_STOP;

  // other reset kinds keep the strap from the last clock-check reset
  always_ff @(posedge CLK)
  begin
    if (RST && clk_check)
      osc_ff <= OSC_SELECT_INPUT;
  end

  // --------------------------------------------------------------------------
  // device-level wiring, registered so every output is a flop
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      trig_ff <= 4'h0;
      frz_ff <= 1'b0;
      bdmclk_ff <= 1'b1;
      ch17_ff <= 1'b0;
      bg_ff <= 1'b0;
    end
    else
    begin
      trig_ff <= {PIT_TRIG1, PIT_TRIG0, PWM_CH3, PWM_CH1};
      frz_ff <= BDM_ACTIVE;
      bdmclk_ff <= 1'b1;
      ch17_ff <= (ADC_CHAN_CODE == rol_pkg::CH17_CODE);
      bg_ff <= sens_sel_ff;
    end
  end

  // --------------------------------------------------------------------------
  // register read port; reserved and unmapped space read zero, no error
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST || !REG_RD || in_rsvd(REG_ADDR))
      rdata_ff <= 8'h00;
    else
    begin
      unique case (REG_ADDR)
        rol_pkg::REG_STATUS:
          rdata_ff <= {3'h0, (ht_ff == rol_pkg::HT_TRIM_GOOD), osc_ff, fsec_ff,
            busy_ff, (state_ff == ST_RUN)};
        rol_pkg::REG_WDOG: rdata_ff <= {4'h0, win_ff, rate_ff};
        rol_pkg::REG_WAKE: rdata_ff <= {2'h0, wake_ff};
        rol_pkg::REG_HTTRIM: rdata_ff <= {4'h0, ht_ff};
        rol_pkg::REG_VCTRL: rdata_ff <= {7'h00, sens_sel_ff};
        rol_pkg::REG_OPTION: rdata_ff <= option_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign OSC_LOOP_CTRL = osc_ff;
  assign FORCE_SECURE = fsec_ff;
  assign FLASH_CMD_ABORT = abort_ff;
  assign CPU_HOLD = hold_ff;
  assign WATCHDOG_RATE = rate_ff;
  assign WATCHDOG_WINDOW_EN = win_ff;
  assign WAKEUP_TRIM = wake_ff;
  assign HIGH_TEMP_TRIM = ht_ff;
  assign ADC_EXT_TRIG = trig_ff;
  assign ADC_FREEZE = frz_ff;
  assign BDM_ALT_CLK_OSC = bdmclk_ff;
  assign CH17_ACTIVE = ch17_ff;
  assign CH17_BANDGAP = bg_ff;
  assign REG_RDATA = rdata_ff;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence opt_done_s;
    load_step && (state_ff == ST_OPT);
  endsequence

  sequence load_end_s;
    load_step && (state_ff == ST_HT);
  endsequence

  reset_stall_a: assert property (disable iff (1'b0) RST |=> CPU_HOLD)
    else $error("cpu not held during reset");
  stall_release_a: assert property ($fell(CPU_HOLD) |-> $past(state_ff) == ST_HT)
    else $error("cpu released before load ended");
  run_no_hold_a: assert property (load_end_s |=> !CPU_HOLD && (state_ff == ST_RUN))
    else $error("cpu still held after load");
  fault_sec_a: assert property (load_step && fif.fault |=> FORCE_SECURE)
    else $error("double fault did not force security");
  cmd_abort_a: assert property (disable iff (1'b0)
    RST && FLASH_CMD_ACTIVE |=> FLASH_CMD_ABORT)
    else $error("flash command not aborted");
  opt_addr_a: assert property (start_ff && (state_ff == ST_OPT)
    |-> faddr_ff == rol_pkg::OPT_BYTE_ADDR ##1 FLASH_ADDR == rol_pkg::OPT_BYTE_ADDR)
    else $error("option byte fetched from wrong address");
  rate_inv_a: assert property (opt_done_s ##0 !(SECURED && SPECIAL_SC)
    |=> WATCHDOG_RATE == ~$past(fif.data[2:0]))
    else $error("watchdog rate not inverted option");
  window_inv_a: assert property (opt_done_s |=> WATCHDOG_WINDOW_EN == !$past(fif.data[3]))
    else $error("window enable not inverted option");
  secure_rate_a: assert property (opt_done_s ##0 (SECURED && SPECIAL_SC)
    |=> WATCHDOG_RATE == 3'h7)
    else $error("secured special mode rate not longest");
  trig_map_a: assert property (!$past(RST) |-> ADC_EXT_TRIG ==
    $past({PIT_TRIG1, PIT_TRIG0, PWM_CH3, PWM_CH1}))
    else $error("external trigger routing wrong");
  freeze_bdm_a: assert property (!$past(RST) |-> ADC_FREEZE == $past(BDM_ACTIVE))
    else $error("freeze does not follow debug");
  ch17_code_a: assert property (!$past(RST) |->
    CH17_ACTIVE == ($past(ADC_CHAN_CODE) == 5'h11))
    else $error("channel 17 decode wrong");
  wake_load_a: assert property (load_step && (state_ff == ST_WAKE)
    |=> WAKEUP_TRIM == $past(fif.data[5:0]))
    else $error("wakeup trim not loaded");
  rsvd_zero_a: assert property (REG_RD && in_rsvd(REG_ADDR) |=> REG_RDATA == 8'h00)
    else $error("reserved space read nonzero");
  ht_load_a: assert property (load_end_s |=> HIGH_TEMP_TRIM == $past(fif.data[3:0]))
    else $error("high temperature trim not loaded");
  sens_sel_a: assert property (##2 CH17_BANDGAP == $past(sens_sel_ff, 1))
    else $error("channel 17 source select wrong");
  bdm_clk_a: assert property (##1 BDM_ALT_CLK_OSC)
    else $error("debug clock not oscillator");
  osc_hold_a: assert property (!RST && !$past(RST) |-> $stable(OSC_LOOP_CTRL))
    else $error("oscillator select changed after release");
  osc_sample_a: assert property (disable iff (1'b0) RST && clk_check
    |=> OSC_LOOP_CTRL == $past(OSC_SELECT_INPUT))
    else $error("oscillator select not sampled");
endmodule // rol_loader
`default_nettype wire

// ### verification/rol_flash_model.sv
// flash array model that serves the option bytes fetched during the reset load
`default_nettype none
module rol_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // read port
  input wire logic rd_req,
  input wire logic [22:0] addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic dbl_fault,
  // array contents and read behaviour
  input wire logic [7:0] opt_byte,
  input wire logic [7:0] wake_byte,
  input wire logic [7:0] ht_byte,
  input wire logic [3:0] wait_cyc,
  input wire logic [2:0] fault_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // array contents
  // --------------------------------------------------------------------------
  logic [7:0] word;
  logic bad;
  logic [3:0] cnt_ff;
  logic served_ff;
  assign word = (addr == rol_pkg::OPT_BYTE_ADDR) ? opt_byte :
    (addr == rol_pkg::WAKE_TRIM_ADDR) ? wake_byte :
    (addr == rol_pkg::HT_TRIM_ADDR) ? ht_byte : 8'hff;
  assign bad = (addr == rol_pkg::OPT_BYTE_ADDR) ? fault_mask[0] :
    (addr == rol_pkg::WAKE_TRIM_ADDR) ? fault_mask[1] : fault_mask[2];
  // --------------------------------------------------------------------------
  // read timing
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    rd_valid <= 1'b0;
    // idle lines wander, so a design that ignores valid picks up junk
    rd_data <= ~rd_data;
    dbl_fault <= ~dbl_fault;
    if (rst || !rd_req)
    begin
      cnt_ff <= 4'h0;
      served_ff <= 1'b0;
    end
    else if (!served_ff)
    begin
      if (cnt_ff == wait_cyc)
      begin
        rd_valid <= 1'b1;
        rd_data <= word;
        dbl_fault <= bad;
        served_ff <= 1'b1;
      end
      else
        cnt_ff <= cnt_ff + 4'h1;
    end
    if (rst)
    begin
      rd_data <= 8'h00;
      dbl_fault <= 1'b0;
    end
  end
endmodule // rol_flash_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the reset option loader
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // stimulus and observation
  // --------------------------------------------------------------------------
  logic CLK = 1'b0, RST = 1'b1, RST_POR_LVR = 1'b0, RST_CLK_MON = 1'b0, RST_SCM_STOP = 1'b0;
  logic OSC_SELECT_INPUT = 1'b0, SECURED = 1'b0, SPECIAL_SC = 1'b0, FLASH_CMD_ACTIVE = 1'b0;
  logic PWM_CH1 = 1'b0, PWM_CH3 = 1'b0, PIT_TRIG0 = 1'b0, PIT_TRIG1 = 1'b0, BDM_ACTIVE = 1'b0;
  logic REG_WR = 1'b0, REG_RD = 1'b0;
  logic [4:0] ADC_CHAN_CODE = 5'h00;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, FLASH_RD_DATA;
  logic [7:0] m_opt = 8'h00, m_wake = 8'h00, m_ht = 8'h00;
  logic [3:0] m_wait = 4'h0, HIGH_TEMP_TRIM, ADC_EXT_TRIG;
  logic [2:0] m_fault = 3'h0, WATCHDOG_RATE;
  logic [22:0] FLASH_ADDR;
  logic [5:0] WAKEUP_TRIM;
  logic OSC_LOOP_CTRL, FORCE_SECURE, FLASH_CMD_ABORT, FLASH_RD_REQ, FLASH_RD_VALID;
  logic FLASH_DBL_FAULT, CPU_HOLD, WATCHDOG_WINDOW_EN, ADC_FREEZE, BDM_ALT_CLK_OSC;
  logic CH17_ACTIVE, CH17_BANDGAP;
  int errors = 0;
  int tests_run = 0;
  always #20 CLK = ~CLK;
  rol_loader dut (
    .CLK, .RST, .RST_POR_LVR, .RST_CLK_MON, .RST_SCM_STOP, .OSC_SELECT_INPUT, .OSC_LOOP_CTRL,
    .SECURED, .SPECIAL_SC, .FORCE_SECURE, .FLASH_CMD_ACTIVE, .FLASH_CMD_ABORT, .FLASH_RD_REQ,
    .FLASH_ADDR, .FLASH_RD_DATA, .FLASH_RD_VALID, .FLASH_DBL_FAULT, .CPU_HOLD, .WATCHDOG_RATE,
    .WATCHDOG_WINDOW_EN, .WAKEUP_TRIM, .HIGH_TEMP_TRIM, .PWM_CH1, .PWM_CH3, .PIT_TRIG0,
    .PIT_TRIG1, .ADC_EXT_TRIG, .BDM_ACTIVE, .ADC_FREEZE, .BDM_ALT_CLK_OSC, .ADC_CHAN_CODE,
    .CH17_ACTIVE, .CH17_BANDGAP, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA
  );
  rol_flash_model flash (.clk(CLK), .rst(RST), .rd_req(FLASH_RD_REQ), .addr(FLASH_ADDR),
    .rd_data(FLASH_RD_DATA), .rd_valid(FLASH_RD_VALID), .dbl_fault(FLASH_DBL_FAULT),
    .opt_byte(m_opt), .wake_byte(m_wake), .ht_byte(m_ht), .wait_cyc(m_wait),
    .fault_mask(m_fault));
  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  // reset, follow the three fetches and judge every loaded control
  task automatic load(input logic [7:0] opt, input logic [2:0] fmask, input logic [3:0] lat);
    int n;
    int seen;
    logic [22:0] a [3];
    @(posedge CLK);
    RST <= 1'b1;
    m_opt <= opt;
    m_wake <= ~opt;
    m_ht <= opt + 8'h13;
    m_wait <= lat;
    m_fault <= fmask;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    #1 chk(CPU_HOLD, 1'b1);
    n = 0;
    seen = 0;
    while (CPU_HOLD !== 1'b0 && n < 300)
    begin
      if (FLASH_RD_VALID === 1'b1 && FLASH_RD_REQ === 1'b1 && seen < 3)
      begin
        a[seen] = FLASH_ADDR;
        seen++;
      end
      @(posedge CLK);
      #1 n++;
    end
    chk(seen, 3);
    chk(a[0], rol_pkg::OPT_BYTE_ADDR);
    chk(a[1], rol_pkg::WAKE_TRIM_ADDR);
    chk(a[2], rol_pkg::HT_TRIM_ADDR);
    chk(WATCHDOG_RATE, (SECURED && SPECIAL_SC) ? rol_pkg::RATE_LONGEST : 3'(~opt[2:0]));
    chk(WATCHDOG_WINDOW_EN, !opt[3]);
    chk(WAKEUP_TRIM, m_wake[5:0]);
    chk(HIGH_TEMP_TRIM, m_ht[3:0]);
    chk(FORCE_SECURE, |fmask);
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_osc();
    for (int i = 0; i < 3; i++)
    begin
      {RST_SCM_STOP, RST_CLK_MON, RST_POR_LVR} <= 3'h1 << i;
      OSC_SELECT_INPUT <= ~i[0];
      load(8'h00, 3'h0, 4'h0);
      // strap moves only after release, as the external driver must
      OSC_SELECT_INPUT <= i[0];
      {RST_SCM_STOP, RST_CLK_MON, RST_POR_LVR} <= 3'h0;
      repeat (3) @(posedge CLK);
      #1 chk(OSC_LOOP_CTRL, !i[0]);
    end
    load(8'h00, 3'h0, 4'h0);
    chk(OSC_LOOP_CTRL, 1'b1);
  endtask
  task automatic t_rate();
    logic [7:0] d;
    for (int v = 0; v < 16; v++)
    begin
      load({4'ha, v[3:0]}, 3'h0, {v[1:0], 2'h1});
      rd(rol_pkg::REG_WDOG, d);
      chk(d, {4'h0, ~v[3], ~v[2:0]});
    end
  endtask
  task automatic t_secure();
    SECURED <= 1'b1;
    SPECIAL_SC <= 1'b1;
    load(8'h02, 3'h0, 4'h2);
    SPECIAL_SC <= 1'b0;
    load(8'h02, 3'h0, 4'h2);
    SECURED <= 1'b0;
  endtask
  task automatic t_fault();
    for (int i = 0; i < 3; i++)
      load(8'h0c, 3'h1 << i, 4'h3);
  endtask
  task automatic t_abort();
    @(posedge CLK);
    FLASH_CMD_ACTIVE <= 1'b1;
    @(posedge CLK);
    RST <= 1'b1;
    #1 chk(FLASH_CMD_ABORT, 1'b0);
    @(posedge CLK);
    FLASH_CMD_ACTIVE <= 1'b0;
    #1 chk(FLASH_CMD_ABORT, 1'b1);
    @(posedge CLK);
    #1 chk(FLASH_CMD_ABORT, 1'b0);
    load(8'h00, 3'h0, 4'h0);
  endtask
  task automatic t_regs();
    logic [7:0] d;
    wr(rol_pkg::RSVD_LO, 8'hff);
    rd(rol_pkg::RSVD_LO, d);
    chk(d, 8'h00);
    wr(rol_pkg::RSVD_HI, 8'h5a);
    rd(rol_pkg::RSVD_HI, d);
    chk(d, 8'h00);
    rd(8'h20, d);
    chk(d, 8'h00);
    rd(rol_pkg::REG_WDOG, d);
    chk(d, 8'h0f);
    // strap kept high, no fault, fetch idle, load finished
    rd(rol_pkg::REG_STATUS, d);
    chk(d, 8'h09);
  endtask
  task automatic t_wire();
    for (int i = 0; i < 4; i++)
    begin
      {PIT_TRIG1, PIT_TRIG0, PWM_CH3, PWM_CH1} <= 4'h1 << i;
      @(posedge CLK);
      #1 chk(ADC_EXT_TRIG, 4'h1 << i);
    end
    BDM_ACTIVE <= 1'b1;
    @(posedge CLK);
    #1 chk(ADC_FREEZE, 1'b1);
    BDM_ACTIVE <= 1'b0;
    @(posedge CLK);
    #1 chk(ADC_FREEZE, 1'b0);
    chk(BDM_ALT_CLK_OSC, 1'b1);
    for (int c = 0; c < 32; c++)
    begin
      ADC_CHAN_CODE <= c[4:0];
      @(posedge CLK);
      #1 chk(CH17_ACTIVE, c == 17);
    end
  endtask
  task automatic t_sensor();
    wr(rol_pkg::REG_VCTRL, 8'h01);
    @(posedge CLK);
    #1 chk(CH17_BANDGAP, 1'b1);
    wr(rol_pkg::REG_VCTRL, 8'h00);
    @(posedge CLK);
    #1 chk(CH17_BANDGAP, 1'b0);
  endtask
  // --------------------------------------------------------------------------
  // sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    t_osc();
    t_rate();
    t_secure();
    t_fault();
    t_abort();
    t_regs();
    t_wire();
    t_sensor();
    print_verdict();
  end
  // the whole sequence needs a few thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge CLK);
    errors++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
